// [hdl/led_matrix_map.svh]
// Register indices, field positions and reset values of the LED matrix bank
`ifndef LED_MATRIX_MAP_SVH
`define LED_MATRIX_MAP_SVH
// Register indices; byte address is four times the index
`define LM_IDX_CLOCK_AND_CURRENT_CTRL    6'h03
`define LM_IDX_MODE      6'h04
`define LM_IDX_FRAME_WRITE_SELECT    6'h05
`define LM_IDX_BMP_FIRST 6'h06
`define LM_IDX_BMP_LAST  6'h17
`define LM_IDX_VOLTAGE_THRESHOLD_ONEHOT     6'h18
`define LM_IDX_MELODY    6'h19
`define LM_IDX_IRQFLAG   6'h1a
`define LM_IDX_IRQMASK   6'h1b
`define LM_IDX_DETECT    6'h1c
// Reset values
`define LM_RST_CLOCK_AND_CURRENT_CTRL    8'h78
`define LM_RST_ZERO8     8'h00
`define LM_RST_MASK      4'hf
// Clock and current fields
`define LM_BIT_RANGE     7
`define LM_POS_STEP      3
`define LM_BIT_OSC_ENABLE     2
`define LM_BIT_INTERNAL_CLK_DRIVE_OUT    1
`define LM_BIT_EXTERNAL_CLK_SELECT    0
// Mode register fields
`define LM_BIT_GHOST     3
`define LM_POS_MODE      1
`define LM_BIT_RUN       0
// Melody register fields
`define LM_POS_COMP      4
`define LM_POS_GROUP     0
// Current step per code count, low and high range, in mA
`define LM_STEP_LO_MA    7'd2
`define LM_STEP_HI_MA    7'd4
// Bitmap size
`define LM_BMP_ROWS      18
`define LM_LEDS          144
`endif

// [hdl/led_matrix_pkg.sv]
// Types shared by the LED matrix control register bank
package led_matrix_pkg;
    typedef enum logic [1:0] {
        MODE_FRAME1,
        MODE_FRAME2,
        MODE_MELODY,
        MODE_SCROLL
    } matrix_mode_e;

    // Whole state of the register bank
    typedef struct packed {
        logic         ack;
        logic [7:0]   rdat;
        logic [7:0]   clk_ctl;
        logic [7:0]   mode_ctl;
        logic         frame_sel;
        logic [7:0]   voltage_threshold_onehot;
        logic [6:0]   melody;
        logic [3:0]   flags;
        logic [3:0]   mask;
        logic         detect;
        logic         scroll_shown;
        logic [143:0] frame1;
        logic [143:0] frame2;
        logic         int_clk;
        logic         core_clk;
        logic         clk_oe_n;
    } state_s;

    // Decoded view of the control fields
    typedef struct packed {
        logic         range_hi;
        logic [6:0]   current_ma;
        logic         osc_run;
        logic         ext_clk;
        logic         clk_out;
        logic         ghost;
        logic         run;
        matrix_mode_e mode;
        logic         melody_eff;
        logic [3:0]   thresh;
        logic [2:0]   comp;
        logic [3:0]   bar_groups;
    } ctrl_s;
endpackage

// [hdl/led_matrix_control_regs.sv]
// Control and status register bank of a 12 by 12 LED matrix driver
//
// Behaviour
// - Bit 7 picks 30 or 60 mA range
// - Bits 6..3 step current, 2 or 4 mA
// - Oscillator runs on enable or matrix on
// - Clock-out bit drives internal clock onto pin
// - Clock-select bit picks internal or external clock
// - External clock beats clock-out beats melody
// - Bit 3 enables ghost image suppression
// - Mode field: frame1, frame2, melody, scroll
// - Bit 0 switches matrix operation on
// - Frame-select steers bitmap writes, melody enables
// - Scroll mode writes the free frame
// - One bit per LED, 06h to 17h
// - Bitmap writes follow frame-select outside scroll mode
// - Melody shows frame 1, frame 2 enables
// - One-hot threshold, zero means automatic
// - Several threshold bits: first one wins
// - Melody compensation field, reset none
// - Group bits make bar meters in melody
// - Flags: test end, open, short, frame
// - Interrupt pin low while any flag set
// - Flags clear only by writing zero
// - Mask per source, all masked after reset
// - Detection enable also starts the matrix
`include "led_matrix_map.svh"

module led_matrix_control_regs
    import led_matrix_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         int_osc_clk_i,
    input  wire logic         clk_pin_bidir_i,
    output logic              clk_pin_bidir_o,
    output logic              clk_pin_bidir_oe_n_o,
    input  wire logic         test_done_i,
    input  wire logic         open_det_i,
    input  wire logic         short_det_i,
    input  wire logic         frame_scroll_done_i,
    output logic              irq_n_o,
    output logic              range_hi_o,
    output logic      [6:0]   led_current_ma_o,
    output logic              osc_run_o,
    output logic              external_clk_select_o,
    output logic              core_clk_o,
    output logic              ghost_suppress_en_o,
    output logic              matrix_run_o,
    output logic      [1:0]   matrix_mode_sel_o,
    output logic              melody_active_o,
    output logic      [143:0] display_bitmap_o,
    output logic      [143:0] melody_enable_map_o,
    output logic      [3:0]   threshold_sel_o,
    output logic      [2:0]   melody_brightness_comp_o,
    output logic      [3:0]   bar_meter_groups_o,
    output logic              detect_en_o
);

    // ======================================================
    // Helpers
    // ======================================================

    // Lowest set bit wins; zero selects automatic detection
    function automatic logic [3:0] first_thresh(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i + 1);
            end
        end
        return r;
    endfunction

    // True when the index falls in the bitmap window
    function automatic logic is_bitmap(input logic [5:0] idx);
        return (idx >= `LM_IDX_BMP_FIRST) && (idx <= `LM_IDX_BMP_LAST);
    endfunction

    state_s     s_q;
    state_s     s_d;
    ctrl_s      c;
    logic [5:0] idx;
    logic [4:0] row;
    logic       req;
    logic       wr_take;
    logic [7:0] wbyte;
    logic [3:0] events;

    // ======================================================
    // Field decode
    // ======================================================

    assign idx   = wb_adr_i[7:2];
    assign row   = 5'(idx - `LM_IDX_BMP_FIRST);
    assign req   = wb_cyc_i && wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign wr_take = req && wb_we_i && s_q.ack && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];
    assign events = {test_done_i, open_det_i, short_det_i,
                     frame_scroll_done_i};

    // Control fields seen by the rest of the driver
    always_comb begin
        c.range_hi = s_q.clk_ctl[`LM_BIT_RANGE];
        c.current_ma = 7'(s_q.clk_ctl[6:3]) *
            (c.range_hi ? `LM_STEP_HI_MA : `LM_STEP_LO_MA);
        c.run  = s_q.mode_ctl[`LM_BIT_RUN];
        // oscillator forced by matrix or detection
        c.osc_run = s_q.clk_ctl[`LM_BIT_OSC_ENABLE] | c.run | s_q.detect;
        c.ext_clk = s_q.clk_ctl[`LM_BIT_EXTERNAL_CLK_SELECT];
        c.clk_out = s_q.clk_ctl[`LM_BIT_INTERNAL_CLK_DRIVE_OUT] & ~c.ext_clk;
        c.ghost = s_q.mode_ctl[`LM_BIT_GHOST];
        c.mode = matrix_mode_e'(s_q.mode_ctl[2:1]);
        // melody has the lowest clock priority
        c.melody_eff = (c.mode == MODE_MELODY) & ~c.ext_clk &
                       ~s_q.clk_ctl[`LM_BIT_INTERNAL_CLK_DRIVE_OUT];
        c.thresh = first_thresh(s_q.voltage_threshold_onehot);
        c.comp = s_q.melody[6:4];
        // bar meters only in melody mode
        c.bar_groups = c.melody_eff ? s_q.melody[3:0] : 4'h0;
    end

    // ======================================================
    // Next state
    // ======================================================

    always_comb begin
        s_d = s_q;
        // Ack for one cycle, then drop even if stb stays
        s_d.ack = req && !s_q.ack;
        s_d.int_clk = int_osc_clk_i;
        s_d.core_clk = c.ext_clk ? clk_pin_bidir_i : s_q.int_clk;
        // drive pin only with clock-out set
        s_d.clk_oe_n = ~c.clk_out;
        // displayed scroll frame swaps at frame end
        if (c.mode == MODE_SCROLL && frame_scroll_done_i) begin
            s_d.scroll_shown = ~s_q.scroll_shown;
        end
        // Read data captured with the ack; bitmap is write-only
        s_d.rdat = 8'h00;
        if (req && !s_q.ack && !wb_we_i) begin
            case (idx)
                `LM_IDX_CLOCK_AND_CURRENT_CTRL:  s_d.rdat = s_q.clk_ctl;
                `LM_IDX_MODE:    s_d.rdat = {4'h0, s_q.mode_ctl[3:0]};
                `LM_IDX_FRAME_WRITE_SELECT:  s_d.rdat = {7'h00, s_q.frame_sel};
                `LM_IDX_VOLTAGE_THRESHOLD_ONEHOT:   s_d.rdat = s_q.voltage_threshold_onehot;
                `LM_IDX_MELODY:  s_d.rdat = {1'b0, s_q.melody};
                `LM_IDX_IRQFLAG: s_d.rdat = {4'h0, s_q.flags};
                `LM_IDX_IRQMASK: s_d.rdat = {4'h0, s_q.mask};
                default:         s_d.rdat = 8'h00;
            endcase
        end
        if (wr_take) begin
            case (idx)
                `LM_IDX_CLOCK_AND_CURRENT_CTRL:  s_d.clk_ctl   = wbyte;
                `LM_IDX_MODE:    s_d.mode_ctl  = {4'h0, wbyte[3:0]};
                `LM_IDX_FRAME_WRITE_SELECT:  s_d.frame_sel = wbyte[0];
                `LM_IDX_VOLTAGE_THRESHOLD_ONEHOT:   s_d.voltage_threshold_onehot     = wbyte;
                `LM_IDX_MELODY:  s_d.melody    = wbyte[6:0];
                `LM_IDX_IRQMASK: s_d.mask      = wbyte[3:0];
                `LM_IDX_DETECT:  s_d.detect    = wbyte[0];
                default: begin
                    if (is_bitmap(idx)) begin
                        if (c.mode == MODE_SCROLL ? !s_q.scroll_shown
                                                  : s_q.frame_sel) begin
                            s_d.frame2[row*8 +: 8] = wbyte;
                        end else begin
                            s_d.frame1[row*8 +: 8] = wbyte;
                        end
                    end
                end
            endcase
        end
        // writing zero clears, writing one keeps
        if (wr_take && idx == `LM_IDX_IRQFLAG) begin
            s_d.flags = s_q.flags & wbyte[3:0];
        end
        // unmasked events set; set beats clear
        s_d.flags = s_d.flags | (events & ~s_q.mask);
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q              <= '0;
            s_q.clk_ctl      <= `LM_RST_CLOCK_AND_CURRENT_CTRL;
            s_q.mode_ctl     <= `LM_RST_ZERO8;
            s_q.voltage_threshold_onehot        <= `LM_RST_ZERO8;
            s_q.mask         <= `LM_RST_MASK;
            s_q.clk_oe_n     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Outputs
    // ======================================================

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = {24'h000000, s_q.rdat};
    assign clk_pin_bidir_o      = s_q.int_clk;
    assign clk_pin_bidir_oe_n_o = s_q.clk_oe_n;
    // pin low while any flag stands
    assign irq_n_o = ~(|s_q.flags);
    assign range_hi_o            = c.range_hi;
    assign led_current_ma_o      = c.current_ma;
    assign osc_run_o             = c.osc_run;
    assign external_clk_select_o = c.ext_clk;
    assign core_clk_o            = s_q.core_clk;
    assign ghost_suppress_en_o   = c.ghost;
    assign matrix_run_o          = c.run | s_q.detect;
    assign matrix_mode_sel_o     = s_q.mode_ctl[2:1];
    assign melody_active_o       = c.melody_eff;
    // melody shows frame 1 and uses frame 2 as enables
    assign display_bitmap_o =
        (c.mode == MODE_FRAME2) ? s_q.frame2 :
        (c.mode == MODE_SCROLL && s_q.scroll_shown) ? s_q.frame2 :
        s_q.frame1;
    assign melody_enable_map_o = c.melody_eff ? s_q.frame2 : '0;
    assign threshold_sel_o          = c.thresh;
    assign melody_brightness_comp_o = c.comp;
    assign bar_meter_groups_o       = c.bar_groups;
    assign detect_en_o              = s_q.detect;

    // ======================================================
    // Checks
    // ======================================================

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    range_sel_a: assert property (
        range_hi_o == s_q.clk_ctl[7])
        else $error("range select mismatch");
    step_current_a: assert property (
        led_current_ma_o == (range_hi_o ? 7'(s_q.clk_ctl[6:3]) * 7'd4
                                        : 7'(s_q.clk_ctl[6:3]) * 7'd2))
        else $error("current step wrong");
    osc_forced_a: assert property (
        matrix_run_o |-> osc_run_o)
        else $error("oscillator off with matrix on");
    clk_drive_a: assert property (
        (s_q.clk_ctl[1] && !s_q.clk_ctl[0]) |=> !clk_pin_bidir_oe_n_o)
        else $error("clock pin not driven");
    ext_priority_a: assert property (
        s_q.clk_ctl[0] |-> !melody_active_o ##1 clk_pin_bidir_oe_n_o)
        else $error("external clock priority broken");
    flag_set_a: assert property (
        (test_done_i && !s_q.mask[3]) |=> s_q.flags[3] && !irq_n_o)
        else $error("test end flag not set");
    flag_clear_a: assert property (
        (s_q.flags[0] && !(wr_take && idx == 6'h1a && !wbyte[0]))
        |=> s_q.flags[0])
        else $error("flag lost without zero write");
    irq_release_a: assert property (
        (s_q.flags == 4'h0) |-> irq_n_o)
        else $error("interrupt held with no flag");
    thresh_first_a: assert property (
        (s_q.voltage_threshold_onehot == 8'h06) |-> threshold_sel_o == 4'h2)
        else $error("threshold priority wrong");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    read_cov_c:   cover property (req && !wb_we_i ##1 wb_ack_o);
    melody_cov_c: cover property (melody_active_o && |s_q.frame2);
    irq_cov_c:    cover property (!irq_n_o ##[1:20] irq_n_o);
endmodule

// [testbench/wb_host_model.sv]
// Wishbone classic host model that reaches the register bank
module wb_host_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        {cyc_o, stb_o, we_o} = 3'b000;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_00ff;
    end

    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [5:0] idx,
                        input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'h1;
        dat_o <= {24'h000000, wd};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~dat_o; // Released data must not look valid
    endtask
endmodule

// [testbench/led_matrix_control_regs_tb.sv]
// Self-checking bench for the LED matrix control register bank
module led_matrix_control_regs_tb import led_matrix_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, nrst_i, cyc, stb, we, ack, osc, po, oe_n, irq_n;
    logic rhi, orun, ext, core, ghost, run, mel, det;
    logic [7:0] adr;
    logic [3:0] sel, ev, thr, bars;
    logic [31:0] dw, dr;
    logic [6:0] cur;
    logic [1:0] mode;
    logic [2:0] comp;
    logic [143:0] disp, men;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    wb_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));

    led_matrix_control_regs DUT (.clk_i(clk_i), .nrst_i(nrst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .int_osc_clk_i(osc), .clk_pin_bidir_i(oe_n ? ~osc : po),
        .clk_pin_bidir_o(po), .clk_pin_bidir_oe_n_o(oe_n),
        .test_done_i(ev[3]), .open_det_i(ev[2]), .short_det_i(ev[1]),
        .frame_scroll_done_i(ev[0]), .irq_n_o(irq_n), .range_hi_o(rhi),
        .led_current_ma_o(cur), .osc_run_o(orun),
        .external_clk_select_o(ext), .core_clk_o(core),
        .ghost_suppress_en_o(ghost), .matrix_run_o(run),
        .matrix_mode_sel_o(mode), .melody_active_o(mel),
        .display_bitmap_o(disp), .melody_enable_map_o(men),
        .threshold_sel_o(thr), .melody_brightness_comp_o(comp),
        .bar_meter_groups_o(bars), .detect_en_o(det));

    // ==========================================================
    // Helpers
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Oscillator stand-in and hang guard
    always @(posedge clk_i) begin
        osc <= ~osc;
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Wait lets the edge's updates land before sampling
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b1, i, d, x);
        #1;
    endtask

    task automatic rdchk(input logic [5:0] i, input logic [7:0] e,
                         input string nm);
        logic [7:0] x;
        host.xfer(1'b0, i, 8'h00, x);
        chk(nm, e, x);
    endtask

    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev <= 4'h0;
        wait_n(1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rdchk(6'h03, 8'h78, "clk_ctl");
        rdchk(6'h04, 8'h00, "mode_ctl");
        rdchk(6'h18, 8'h00, "voltage_threshold_onehot");
        rdchk(6'h19, 8'h00, "melody");
        rdchk(6'h1a, 8'h00, "flags");
        rdchk(6'h1b, 8'h0f, "mask");
        rdchk(6'h3f, 8'h00, "unmapped");
        chk("current", 30, cur);
        chk("clk oe_n", 1, oe_n);
        $display("test reset done");
    endtask

    task automatic t_ctrl;
        wr(6'h03, 8'h88);
        chk("range", 1, rhi);
        chk("current", 4, cur);
        wr(6'h03, 8'h78);
        chk("current", 30, cur);
        chk("osc off", 0, orun);
        wr(6'h04, 8'h09);
        chk("osc auto", 1, orun);
        chk("run", 1, run);
        chk("ghost", 1, ghost);
        for (int m = 0; m < 4; m++) begin
            wr(6'h04, {5'h00, m[1:0], 1'b1});
            chk("mode", m, mode);
        end
        wr(6'h04, 8'h05);
        wr(6'h03, 8'h7b);
        wait_n(3);
        chk("ext", 1, ext);
        chk("melody", 0, mel);
        chk("clk oe_n", 1, oe_n);
        wr(6'h03, 8'h7a);
        wait_n(3);
        chk("clk oe_n", 0, oe_n);
        chk("clk pin", !osc, po);
        chk("melody", 0, mel);
        wr(6'h03, 8'h78);
        wait_n(3);
        chk("melody", 1, mel);
        chk("clk oe_n", 1, oe_n);
        $display("test control done");
    endtask

    task automatic t_bitmap;
        wr(6'h05, 8'h00);
        wr(6'h06, 8'ha5);
        wr(6'h17, 8'h81);
        wr(6'h05, 8'h01);
        wr(6'h06, 8'h3c);
        chk("shown", 8'ha5, disp[7:0]);
        chk("last row", 8'h81, disp[143:136]);
        chk("enables", 8'h3c, men[7:0]);
        rdchk(6'h06, 8'h00, "bitmap rd");
        wr(6'h04, 8'h03);
        chk("frame2", 8'h3c, disp[7:0]);
        chk("no enables", 0, men[7:0]);
        wr(6'h04, 8'h07);
        wr(6'h05, 8'h00);
        wr(6'h06, 8'h5a);
        chk("scroll", 8'ha5, disp[7:0]);
        pulse(0);
        chk("scroll", 8'h5a, disp[7:0]);
        chk("masked irq", 1, irq_n);
        $display("test bitmap done");
    endtask

    task automatic t_misc;
        wr(6'h18, 8'h0c);
        chk("voltage_threshold_onehot", 3, thr);
        wr(6'h18, 8'h80);
        chk("voltage_threshold_onehot", 8, thr);
        // Threshold back to automatic; bar meters only in melody mode
        wr(6'h18, 8'h00);
        chk("voltage_threshold_onehot", 0, thr);
        wr(6'h04, 8'h05);
        wr(6'h19, 8'h5f);
        chk("comp", 5, comp);
        chk("bars", 4'hf, bars);
        wr(6'h04, 8'h01);
        chk("bars", 0, bars);
        wr(6'h04, 8'h00);
        // Detection alone, run bit clear, starts the matrix
        wr(6'h1c, 8'h01);
        chk("detect", 1, det);
        chk("run", 1, run);
        wr(6'h1c, 8'h00);
        $display("test misc done");
    endtask

    task automatic t_irq;
        wr(6'h1b, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            chk("irq_n", 0, irq_n);
            rdchk(6'h1a, 8'h01 << i, "flag");
            wr(6'h1a, 8'hff);
            rdchk(6'h1a, 8'h01 << i, "flag");
            wr(6'h1a, 8'h00);
            chk("irq_n", 1, irq_n);
        end
        $display("test irq done");
    endtask

    initial begin
        nrst_i = 1'b0;
        ev = 4'h0;
        osc = 1'b0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset;
        t_ctrl;
        t_bitmap;
        t_misc;
        t_irq;
        report_and_stop;
    end
endmodule
